// ===== rtl/uart_err_baud.sv
// Purpose: Receive error flags, baud generator and port direction over APB
// Assumes: Pins and timer output synchronous to pclk
// Notes:   Power-off clear is synchronous; pclk keeps running meanwhile
//
// What this block does
// - Parity mismatch at reception end sets parity error bit 2
// - Missing stop bit at reception end sets framing error bit 1
// - Completion while buffer still unread sets overrun bit 0
// - Flags clear when power off, receive off, or status read
// - Only the first stop bit is checked for framing error
// - On overrun the new byte is dropped, old byte kept
// - Parity flag behaviour follows the two parity select bits
// - Zero-parity mode never checks parity nor sets its flag
// - Status read inserts one wait cycle; software avoids stopped clock
// - Status register read-only, reset 00, bits 7..3 read zero
// - Clock select: timer output, divide by 2, 8 or 32
// - Counter divides base clock by k, 8 to 31
// - Bit rate is counter output divided by two
// - Baud control register reset 1F, bit 5 reads zero
// - Direction bit 0 drives pin, 1 leaves it input
// - Direction register read/write, reset FF, all inputs
// - Power off stops unit clock and resets its state
`timescale 1ns/1ns
module uart_err_baud
  import uart_err_baud_pkg::*;
#(
  parameter int DIV_W  = 5,
  parameter int PORT_W = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Timer and line
  input  wire logic              eight_bit_timer_output,
  input  wire logic              serial_rx_pin,
  // Outputs to the pins and transmitter
  output logic [PORT_W-1:0]      port1_drive_en,
  output logic                   serial_bit_clock
);

  // ***************************************************************
  // Registers and wires
  // ***************************************************************
  logic [7:0]        serial_mode_register;
  logic [7:0]        baud_generator_control;
  logic [PORT_W-1:0] port1_direction;
  logic [7:0]        receive_buffer;
  logic              buf_full_reg;
  logic              parity_error_flag;
  logic              framing_error_flag;
  logic              overrun_error_flag;
  logic              wait_reg;
  logic [4:0]        pre_reg;
  logic              timer_prev_reg;
  logic [DIV_W-1:0]  div_cnt_reg;
  logic              base_tick;
  logic              div_tick;
  logic              unit_power_enable;
  logic              receive_enable_bit;
  logic              rx_run;
  logic              rx_line;
  parity_mode_t      par_mode;
  base_sel_t         base_sel;
  logic [DIV_W-1:0]  div_k;
  logic              frame_done;
  logic [7:0]        frame_data;
  logic              frame_parity;
  logic              frame_stop_ok;
  logic              parity_bad;
  logic              setup_ph;
  logic              access_done;
  logic              wr_done;
  logic              rd_err_done;
  logic              rd_buf_done;
  logic [7:0]        rd_value;
  logic              rd_hit;

  assign unit_power_enable  = serial_mode_register[MODE_POWER];
  assign receive_enable_bit = serial_mode_register[MODE_RXE];
  assign rx_run   = unit_power_enable && receive_enable_bit;
  assign par_mode = parity_mode_t'(serial_mode_register[MODE_PS_HI:MODE_PS_LO]);
  assign base_sel = base_sel_t'(baud_generator_control[BAUD_SEL_HI:BAUD_SEL_LO]);
  assign div_k    = baud_generator_control[BAUD_DIV_HI -: DIV_W];
  // Line reads idle high while the unit is off
  assign rx_line  = serial_rx_pin || !unit_power_enable;

  // Is this address the given register index
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == addr_of(idx));
  endfunction : hit

  // Parity check for the selected mode; zero parity and none never fail
  function automatic logic parity_fails(input parity_mode_t m,
                                        input logic [7:0] d,
                                        input logic p);
    unique case (m)
      PAR_ODD:  parity_fails = ~(^d ^ p);
      PAR_EVEN: parity_fails = ^d ^ p;
      default:  parity_fails = 1'b0;
    endcase
  endfunction : parity_fails

  // ***************************************************************
  // APB handshake
  // ***************************************************************
  assign setup_ph    = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done     = access_done && pwrite;
  assign rd_err_done = access_done && !pwrite && hit(paddr, IDX_ERR);
  assign rd_buf_done = access_done && !pwrite && hit(paddr, IDX_RXBUF);

  // Read mux; reserved status bits and unmapped words read zero
  always_comb begin
    rd_value = 8'h00;
    rd_hit   = 1'b1;
    if (hit(paddr, IDX_PORT1_DIR)) begin
      rd_value = port1_direction;
    end else if (hit(paddr, IDX_MODE)) begin
      rd_value = serial_mode_register;
    end else if (hit(paddr, IDX_BAUD)) begin
      rd_value = baud_generator_control & BAUD_WMASK;
    end else if (hit(paddr, IDX_RXBUF)) begin
      rd_value = receive_buffer;
    end else if (hit(paddr, IDX_ERR)) begin
      rd_value = {5'h00, parity_error_flag, framing_error_flag, overrun_error_flag};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Ready: one cycle into access normally, a second for the status read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready   <= 1'b0;
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= setup_ph && !pwrite && hit(paddr, IDX_ERR);
      if (access_done) begin
        pready <= 1'b0;
      end else if (setup_ph) begin
        pready <= !(!pwrite && hit(paddr, IDX_ERR));
      end else begin
        pready <= wait_reg;
      end
    end
  end

  // Read data and error answer are loaded with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if ((setup_ph && !(!pwrite && hit(paddr, IDX_ERR))) || wait_reg) begin
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_value};
      pslverr <= !rd_hit;
    end else if (access_done) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

  // ***************************************************************
  // Software registers
  // ***************************************************************
  // Mode register; bit 0 is held at one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode_register <= RST_MODE;
    end else if (wr_done && hit(paddr, IDX_MODE)) begin
      serial_mode_register <= pwdata[7:0] | MODE_FIXED;
    end
  end

  // Baud control; bit 5 is never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_generator_control <= RST_BAUD;
    end else if (wr_done && hit(paddr, IDX_BAUD)) begin
      baud_generator_control <= pwdata[7:0] & BAUD_WMASK;
    end
  end

  // Port direction and the drive enables that follow it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_direction <= RST_PORT1_DIR;
      port1_drive_en  <= ~RST_PORT1_DIR;
    end else if (wr_done && hit(paddr, IDX_PORT1_DIR)) begin
      port1_direction <= pwdata[PORT_W-1:0];
      port1_drive_en  <= ~pwdata[PORT_W-1:0];
    end
  end

  // ***************************************************************
  // Baud generator
  // ***************************************************************
  // Prescaler and timer edge; the prescaler halts while the unit is off, the timer edge keeps being sampled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg        <= '0;
      timer_prev_reg <= 1'b0;
    end else if (!unit_power_enable) begin
      pre_reg        <= '0;
      timer_prev_reg <= eight_bit_timer_output;
    end else begin
      pre_reg        <= pre_reg + 1'b1;
      timer_prev_reg <= eight_bit_timer_output;
    end
  end

  // Base clock as a one-cycle enable
  always_comb begin
    unique case (base_sel)
      SEL_TIMER: base_tick = eight_bit_timer_output && !timer_prev_reg;
      SEL_DIV2:  base_tick = (pre_reg & PRE_MASK_DIV2) == PRE_MASK_DIV2;
      SEL_DIV8:  base_tick = (pre_reg & PRE_MASK_DIV8) == PRE_MASK_DIV8;
      SEL_DIV32: base_tick = (pre_reg & PRE_MASK_DIV32) == PRE_MASK_DIV32;
    endcase
  end

  // Values below the minimum are illegal; treat them as the minimum
  assign div_tick = base_tick && unit_power_enable &&
                    (div_cnt_reg >= ((div_k < DIV_MIN) ? DIV_MIN : div_k) - 1'b1);

  // Counter by k, then a toggle halves it to the bit rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg      <= '0;
      serial_bit_clock <= 1'b0;
    end else if (!unit_power_enable) begin
      div_cnt_reg      <= '0;
      serial_bit_clock <= 1'b0;
    end else if (base_tick) begin
      div_cnt_reg <= div_tick ? '0 : div_cnt_reg + 1'b1;
      if (div_tick) begin
        serial_bit_clock <= ~serial_bit_clock;
      end
    end
  end

  // ***************************************************************
  // Receiver and error flags
  // ***************************************************************
  uart_rx_frame #(
    .DIV_W         (DIV_W)
  ) u_rx (
    .pclk          (pclk),
    .presetn       (presetn),
    .run           (rx_run),
    .base_tick     (base_tick),
    .div_k         ((div_k < DIV_MIN) ? DIV_MIN : div_k),
    .char8         (serial_mode_register[MODE_CL]),
    .parity_on     (par_mode != PAR_NONE),
    .rx_in         (rx_line),
    .frame_done    (frame_done),
    .frame_data    (frame_data),
    .frame_parity  (frame_parity),
    .frame_stop_ok (frame_stop_ok)
  );

  // Parity depends on mode; zero parity is never judged
  assign parity_bad = parity_fails(par_mode, frame_data, frame_parity);

  // Receive buffer; an overrun leaves the old byte in place
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_buffer <= RST_RXBUF;
      buf_full_reg   <= 1'b0;
    end else if (!unit_power_enable) begin
      receive_buffer <= RST_RXBUF;
      buf_full_reg   <= 1'b0;
    end else if (frame_done && !buf_full_reg) begin
      receive_buffer <= frame_data;
      buf_full_reg   <= 1'b1;
    end else if (rd_buf_done) begin
      buf_full_reg   <= 1'b0;
    end
  end

  // Flags: a frame end in the same cycle as a read still sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_error_flag  <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
    end else if (!rx_run) begin
      parity_error_flag  <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
    end else if (frame_done) begin
      parity_error_flag  <= parity_bad || (parity_error_flag && !rd_err_done);
      framing_error_flag <= !frame_stop_ok || (framing_error_flag && !rd_err_done);
      overrun_error_flag <= buf_full_reg || (overrun_error_flag && !rd_err_done);
    end else if (rd_err_done) begin
      parity_error_flag  <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
    end
  end

endmodule : uart_err_baud

// ===== rtl/uart_err_baud_pkg.sv
// Purpose: Shared constants for the receive error flags and baud generator
// Assumes: APB word access; printed offsets are register indices
// Notes:   Byte address of a register is four times its index
package uart_err_baud_pkg;

  // ***************************************************************
  // Bus and register map
  // ***************************************************************
  localparam int          ADDR_W       = 18;
  localparam logic [15:0] IDX_PORT1_DIR = 16'hff21;
  localparam logic [15:0] IDX_MODE      = 16'hff70;
  localparam logic [15:0] IDX_BAUD      = 16'hff71;
  localparam logic [15:0] IDX_RXBUF     = 16'hff72;
  localparam logic [15:0] IDX_ERR       = 16'hff73;

  // ***************************************************************
  // Reset values and masks
  // ***************************************************************
  localparam logic [7:0] RST_PORT1_DIR = 8'hff;
  localparam logic [7:0] RST_MODE      = 8'h01;
  localparam logic [7:0] RST_BAUD      = 8'h1f;
  localparam logic [7:0] RST_RXBUF     = 8'hff;
  localparam logic [7:0] RST_ERR       = 8'h00;
  localparam logic [7:0] BAUD_WMASK    = 8'hdf;
  localparam logic [7:0] MODE_FIXED    = 8'h01;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE   = 6;
  localparam int MODE_RXE   = 5;
  localparam int MODE_PS_HI = 4;
  localparam int MODE_PS_LO = 3;
  localparam int MODE_CL    = 2;
  localparam int ERR_PE     = 2;
  localparam int ERR_FE     = 1;
  localparam int ERR_OVE    = 0;
  localparam int BAUD_SEL_HI = 7;
  localparam int BAUD_SEL_LO = 6;
  localparam int BAUD_DIV_HI = 4;

  // ***************************************************************
  // Modes and counts
  // ***************************************************************
  typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN} parity_mode_t;
  typedef enum logic [1:0] {SEL_TIMER, SEL_DIV2, SEL_DIV8, SEL_DIV32} base_sel_t;
  localparam logic [4:0] PRE_MASK_DIV2  = 5'h01;
  localparam logic [4:0] PRE_MASK_DIV8  = 5'h07;
  localparam logic [4:0] PRE_MASK_DIV32 = 5'h1f;
  localparam logic [4:0] DIV_MIN        = 5'h08;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] addr_of(input logic [15:0] idx);
    addr_of = {idx, 2'b00};
  endfunction : addr_of

endpackage : uart_err_baud_pkg

// ===== rtl/uart_rx_frame.sv
// Purpose: Receive frame sequencer timed by base clock ticks
// Assumes: rx_in synchronous to pclk; div_k at least 8
// Notes:   One half bit lasts div_k base ticks
`timescale 1ns/1ns
module uart_rx_frame
  import uart_err_baud_pkg::*;
#(
  parameter int DIV_W = 5
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             run,
  input  wire logic             base_tick,
  input  wire logic [DIV_W-1:0] div_k,
  input  wire logic             char8,
  input  wire logic             parity_on,
  // Line
  input  wire logic             rx_in,
  // Frame result
  output logic                  frame_done,
  output logic [7:0]            frame_data,
  output logic                  frame_parity,
  output logic                  frame_stop_ok
);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_HOLD} rx_state_t;

  rx_state_t        state_reg;
  logic [DIV_W:0]   cnt_reg;
  logic [2:0]       bit_reg;
  logic [DIV_W:0]   target;
  logic             sample;

  // Start bit waits one half bit to its middle, other bits two halves
  assign target = (state_reg == RX_START) ? {1'b0, div_k} - 1'b1
                                          : {div_k, 1'b0} - 1'b1;
  assign sample = base_tick && (cnt_reg == target);

  // ***************************************************************
  // Frame sequencer
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= RX_IDLE;
      cnt_reg       <= '0;
      bit_reg       <= '0;
      frame_done    <= 1'b0;
      frame_data    <= '0;
      frame_parity  <= 1'b0;
      frame_stop_ok <= 1'b0;
    end else if (!run) begin
      state_reg  <= RX_IDLE;
      cnt_reg    <= '0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (base_tick) begin
        cnt_reg <= sample ? '0 : cnt_reg + 1'b1;
      end
      unique case (state_reg)
        RX_IDLE: begin
          cnt_reg <= '0;
          if (!rx_in) begin
            state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (sample) begin
            // A glitch that is gone by mid start bit is ignored
            state_reg  <= rx_in ? RX_IDLE : RX_DATA;
            bit_reg    <= '0;
            frame_data <= '0;
          end
        end
        RX_DATA: begin
          if (sample) begin
            frame_data[bit_reg] <= rx_in;
            bit_reg             <= bit_reg + 1'b1;
            if (bit_reg == (char8 ? 3'h7 : 3'h6)) begin
              state_reg <= parity_on ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (sample) begin
            frame_parity <= rx_in;
            state_reg    <= RX_STOP;
          end
        end
        RX_STOP: begin
          // Only the first stop bit is looked at
          if (sample) begin
            frame_stop_ok <= rx_in;
            frame_done    <= 1'b1;
            // A low stop bit must not pass for the next start bit
            state_reg     <= rx_in ? RX_IDLE : RX_HOLD;
          end
        end
        RX_HOLD: begin
          // Wait for the line to go idle after a framing error
          if (rx_in) begin
            state_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

endmodule : uart_rx_frame

// ===== verif/uart_err_baud_props.sv
// Purpose: Port-level checks on the error, baud and direction block
// Assumes: APB master keeps the setup then access order
// Notes:   Bound into every uart_err_baud instance
`timescale 1ns/1ns
module uart_err_baud_props
  import uart_err_baud_pkg::*;
#(
  parameter int PORT_W = 8
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  // Pin and bit clock outputs
  input wire logic [PORT_W-1:0] port1_drive_en,
  input wire logic              serial_bit_clock
);
  // ***************************************************************
  // Helpers
  // ***************************************************************
  localparam logic [ADDR_W-1:0] ERR_A  = {IDX_ERR, 2'b00};
  localparam logic [ADDR_W-1:0] BAUD_A = {IDX_BAUD, 2'b00};
  localparam logic [ADDR_W-1:0] DIR_A  = {IDX_PORT1_DIR, 2'b00};
  logic [8:0] low_cnt;

  // Low time of the bit clock; saturates so long idles stay legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 9'h000;
    end else if (serial_bit_clock) begin
      low_cnt <= 9'h000;
    end else if (low_cnt != 9'h1ff) begin
      low_cnt <= low_cnt + 9'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Status read: setup, one empty access cycle, then ready
  sequence s_err_setup;
    psel && !penable && !pwrite && paddr == ERR_A;
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence

  property p_err_wait;
    s_err_setup |=> s_one_wait;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  property p_err_upper;
    pready && !pwrite && paddr == ERR_A |-> prdata[31:3] == 29'h0;
  endproperty
  property p_baud_bit5;
    pready && !pwrite && paddr == BAUD_A |-> {prdata[31:8], prdata[5]} == 25'h0;
  endproperty
  property p_dir_drive;
    pready && !pwrite && paddr == DIR_A |-> prdata[PORT_W-1:0] == ~port1_drive_en;
  endproperty
  property p_fast;
    psel && !penable && (paddr == DIR_A || paddr == BAUD_A) |=> pready;
  endproperty
  property p_drive_reset;
    $rose(presetn) |-> port1_drive_en == '0;
  endproperty
  property p_bitclk_low;
    $rose(serial_bit_clock) |-> low_cnt >= 9'd15;
  endproperty

  a_err_wait: assert property (p_err_wait) else $error("status read without one wait");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  a_ready_access: assert property (p_ready_access) else $error("ready outside access");
  a_err_upper: assert property (p_err_upper) else $error("status upper bits set");
  a_baud_bit5: assert property (p_baud_bit5) else $error("baud bit 5 not zero");
  a_dir_drive: assert property (p_dir_drive) else $error("drive enable mismatch");
  a_fast: assert property (p_fast) else $error("plain access waited");
  a_drive_reset: assert property (p_drive_reset) else $error("pins driven at reset");
  a_bitclk_low: assert property (p_bitclk_low) else $error("bit clock low too short");

endmodule : uart_err_baud_props

bind uart_err_baud uart_err_baud_props #(.PORT_W(PORT_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .port1_drive_en(port1_drive_en),
  .serial_bit_clock(serial_bit_clock));

// ===== verif/uart_line_partner.sv
// Purpose: Remote serial transmitter feeding the receive pin
// Assumes: Bit time given in pclk cycles by the caller
// Notes:   Line idles high, as a pulled-up serial line does
`timescale 1ns/1ns
module uart_line_partner (
  // Clock
  input wire logic pclk,
  // Serial line
  output logic     line
);
  initial line = 1'b1;

  // One bit held for bt cycles, changed just after an edge
  task automatic bit_out(input logic v, input int bt);
    line <= v;
    repeat (bt) @(posedge pclk);
  endtask : bit_out

  // Start, data LSB first, optional parity, first stop, then idle
  task automatic send(input logic [7:0] d, input int nb, input logic has_par,
                      input logic par, input logic stop, input int bt);
    bit_out(1'b0, bt);
    for (int i = 0; i < nb; i++) begin
      bit_out(d[i], bt);
    end
    if (has_par) begin
      bit_out(par, bt);
    end
    bit_out(stop, bt);
    bit_out(1'b1, 2 * bt);
  endtask : send

endmodule : uart_line_partner

// ===== verif/testbench.sv
// Purpose: Self-checking bench for flags, baud generator and direction
// Assumes: Bit time 32 pclk with baud 48 (divide by 2, k of 8)
// Notes:   Timer stand-in toggles so one base tick lands every 4 pclk
`timescale 1ns/1ns
module testbench;
  import uart_err_baud_pkg::*;
  // ***************************************************************
  // Signals and design
  // ***************************************************************
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic              rx, bclk;
  logic              tmr = 1'b0;
  logic [7:0]        drv, d;
  logic [1:0]        tcnt = 2'd0;
  logic              e;
  int                bad_count, cmp_count, n;
  logic [7:0] bauds[5] = '{8'h48, 8'h88, 8'hc8, 8'h5f, 8'h08};
  int         hp[5]    = '{16, 64, 256, 62, 32};
  logic [7:0] dat[6]   = '{8'h55, 8'h55, 8'ha5, 8'ha5, 8'h3c, 8'hc3};
  logic [7:0] pm[6]    = '{8'h18, 8'h18, 8'h10, 8'h10, 8'h08, 8'h00};
  logic       par[6]   = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic       stp[6]   = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [7:0] est[6]   = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h02};

  uart_err_baud dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eight_bit_timer_output(tmr), .serial_rx_pin(rx), .port1_drive_en(drv),
    .serial_bit_clock(bclk));
  uart_line_partner partner (.pclk(pclk), .line(rx));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Timer stand-in runs from time zero, before it is ever selected
  always @(posedge pclk) begin
    tcnt <= tcnt + 2'd1;
    tmr  <= tcnt[1];
  end

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk8

  task chk_n(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      bad_count++;
      $display("unexpected at %0t: half period %0d want %0d", $time, got, exp);
    end
  endtask : chk_n

  // Waits are bounded; a hang ends the run
  task hang;
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    complete_run();
  endtask : hang

  // One APB transfer, held until pready is seen at an edge
  task apb(input logic w, input logic [15:0] idx, input logic [7:0] wd,
           output logic [7:0] rd, output logic err);
    int i;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) hang();
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [15:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v, d, e);
  endtask : wr

  task rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, d, e);
    chk8(d, exp);
  endtask : rd_chk

  // High time of the bit clock in pclk cycles
  task meas(output int hi);
    int i;
    i = 0;
    hi = 0;
    while (bclk !== 1'b1 && i < 3000) begin
      @(posedge pclk);
      i++;
    end
    while (bclk === 1'b1 && i < 3000) begin
      @(posedge pclk);
      i++;
      hi++;
    end
    if (i >= 3000) hang();
  endtask : meas

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    bad_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(IDX_PORT1_DIR, 8'hff);
    rd_chk(IDX_BAUD, 8'h1f);
    rd_chk(IDX_ERR, 8'h00);
    chk8(drv, 8'h00);
    wr(IDX_PORT1_DIR, 8'hfe);
    @(posedge pclk);
    chk8(drv, 8'h01);
    rd_chk(IDX_PORT1_DIR, 8'hfe);
    wr(IDX_BAUD, 8'hff);
    rd_chk(IDX_BAUD, 8'hdf);
    wr(IDX_ERR, 8'hff);
    rd_chk(IDX_ERR, 8'h00);
    apb(1'b0, 16'h0010, 8'h00, d, e);
    chk8({7'h0, e}, 8'h01);
    // Every clock select, both ends of k, changed only with power off
    for (int i = 0; i < 5; i++) begin
      wr(IDX_MODE, 8'h01);
      wr(IDX_BAUD, bauds[i]);
      wr(IDX_MODE, 8'h81);
      meas(n);
      chk_n(n, hp[i]);
    end
    wr(IDX_MODE, 8'h01);
    wr(IDX_BAUD, 8'h48);
    // Even and odd parity good and bad, zero parity once, then no parity with a missing stop bit
    for (int j = 0; j < 6; j++) begin
      wr(IDX_MODE, 8'h85 | pm[j]);
      wr(IDX_MODE, 8'ha5 | pm[j]);
      partner.send(dat[j], 8, pm[j] != 8'h00, par[j], stp[j], 32);
      rd_chk(IDX_ERR, est[j]);
      rd_chk(IDX_ERR, 8'h00);
      rd_chk(IDX_RXBUF, dat[j]);
    end
    // Second byte arrives while the first is unread
    partner.send(8'h11, 8, 1'b0, 1'b0, 1'b1, 32);
    partner.send(8'h22, 8, 1'b0, 1'b0, 1'b1, 32);
    rd_chk(IDX_ERR, 8'h01);
    rd_chk(IDX_RXBUF, 8'h11);
    partner.send(8'h33, 8, 1'b0, 1'b0, 1'b0, 32);
    wr(IDX_MODE, 8'h85);
    rd_chk(IDX_ERR, 8'h00);
    rd_chk(IDX_RXBUF, 8'h33);
    wr(IDX_MODE, 8'h01);
    rd_chk(IDX_RXBUF, 8'hff);
    complete_run();
  end

endmodule : testbench
